// ### src/dsu_map.svh
// Register offsets, field positions and reset values of the status and loopback block.
`ifndef DSU_MAP_SVH
`define DSU_MAP_SVH

// Byte addresses of the AXI4-Lite registers.
`define OFS_CONTROL     4'h0
`define OFS_STATUS      4'h4
`define OFS_INT_STATUS  4'h8
`define OFS_INT_MASK    4'hC

// Control register fields.
`define CTRL_SW_LOCAL   0
`define CTRL_SW_REMOTE  1
`define CTRL_W          2
`define CTRL_RESET      2'h0

// Event bits, shared by the interrupt status and mask registers.
`define EV_CARRIER_LOST 0
`define EV_BIT_ERROR    1
`define EV_LOOP_ENTER   2
`define EV_NO_SIGNAL    3
`define EV_W            4
`define MASK_RESET      4'h0

// Status register fields.
`define ST_MODE_LO      0
`define ST_PATTERN      2
`define ST_RATE_64      3
`define ST_CARRIER      4
`define ST_BIT_ERROR    5
`define ST_NO_SIGNAL    6
`define ST_LOOP         7

// Bus answers.
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Cycles after reset release before the synchronised rate switch is valid.
`define RATE_SETTLE     2'h2

`endif

// ### src/dsu_pkg.sv
// Types shared by the status and loopback block.
`default_nettype none
package dsu_pkg;

	// Loop state of the unit.
	typedef enum logic [1:0] {
		MODE_NORMAL  = 2'b00,
		MODE_LOCAL   = 2'b01,
		MODE_REMOTE  = 2'b10,
		MODE_RESPOND = 2'b11
	} loop_mode_t;

	// Pin and switch inputs, all from outside the clock domain.
	typedef struct packed {
		logic dte_tx_bit;
		logic line_rx_bit;
		logic carrier_present;
		logic service_violation;
		logic idle_code_detected;
		logic framing_error;
		logic bipolar_violation;
		logic invalid_bipolar;
		logic pattern_error;
		logic toggle_down;
		logic toggle_up;
		logic test_511;
		logic test_511e;
		logic local_loop_request_line;
		logic remote_loop_request_line;
		logic peer_loop_request;
		logic co_loop_active;
		logic no_valid_signal;
		logic line_rate_switch;
		logic front_panel_enable_switch;
		logic terminal_loop_line_enable_switch;
		logic remote_loop_accept_switch;
	} pins_t;

endpackage
`default_nettype wire

// ### src/level_sync.sv
// Two-stage synchroniser for a vector of independent levels.
`default_nettype none
module level_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_t;

	sync_t s_r;
	sync_t s_nxt;

	// The first stage is read only by the second stage.
	always_comb begin
		s_nxt.meta   = d;
		s_nxt.stable = s_r.meta;
	end

	// Both stages clear on reset so the block sees a defined level.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.stable;
endmodule
`default_nettype wire

// ### src/event_flags.sv
// Sticky event flags with write-one-to-clear and a masked interrupt level.
`default_nettype none
module event_flags #(
	parameter int N = 4
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [N-1:0] set,
	input  wire logic [N-1:0] clr,
	input  wire logic [N-1:0] mask,
	output var  logic [N-1:0] status,
	output var  logic         irq
);
	typedef struct packed {
		logic [N-1:0] flags;
		logic         irq;
	} flags_t;

	flags_t s_r;
	flags_t s_nxt;

	// A set in the same cycle as its clear wins, so no event is lost.
	always_comb begin
		s_nxt.flags = (s_r.flags & ~clr) | set;
		s_nxt.irq   = |(s_nxt.flags & mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign status = s_r.flags;
	assign irq    = s_r.irq;
endmodule
`default_nettype wire

// ### src/dsu_status_loop.sv
// Indicator drive and loopback control of a line data service unit, with an AXI4-Lite register file.
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "dsu_map.svh"
`default_nettype none
module dsu_status_loop (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave.
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output var  logic        arready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready,
	// Terminal and line data.
	input  wire logic        dte_tx_bit,
	input  wire logic        line_rx_bit,
	input  wire logic        pattern_tx_bit,
	output var  logic        line_tx_bit,
	output var  logic        dte_rx_bit,
	// Receiver and pattern checker conditions.
	input  wire logic        carrier_present,
	input  wire logic        service_violation,
	input  wire logic        idle_code_detected,
	input  wire logic        framing_error,
	input  wire logic        bipolar_violation,
	input  wire logic        invalid_bipolar,
	input  wire logic        pattern_error,
	input  wire logic        no_valid_signal,
	// Test requests.
	input  wire logic        toggle_down,
	input  wire logic        toggle_up,
	input  wire logic        test_511,
	input  wire logic        test_511e,
	input  wire logic        local_loop_request_line,
	input  wire logic        remote_loop_request_line,
	input  wire logic        peer_loop_request,
	input  wire logic        co_loop_active,
	// Option switches, high in the On position.
	input  wire logic        line_rate_switch,
	input  wire logic        front_panel_enable_switch,
	input  wire logic        terminal_loop_line_enable_switch,
	input  wire logic        remote_loop_accept_switch,
	// Indicators and status outputs.
	output var  logic        carrier_detect,
	output var  logic        led_tx_data,
	output var  logic        led_rx_data,
	output var  logic        led_carrier,
	output var  logic        bit_error_indicator,
	output var  logic        led_loop,
	output var  logic        no_signal_indicator,
	output var  logic        led_power,
	output var  logic        test_mode,
	output var  logic        pattern_test_active,
	output var  logic        remote_loop_command,
	output var  logic        irq
);
	import dsu_pkg::*;

	typedef struct packed {
		loop_mode_t  mode;
		logic [1:0]  rate_wait;
		logic        rate_known;
		logic        rate_64;
		logic [`CTRL_W-1:0] ctrl;
		logic [`EV_W-1:0]   mask;
		logic        aw_have;
		logic [3:0]  aw_addr;
		logic        w_have;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        line_tx;
		logic        dte_rx;
		logic        remote_cmd;
		logic        pattern_on;
		logic        cd;
		logic        led_tx;
		logic        led_rx;
		logic        led_ber;
		logic        led_loop;
		logic        led_ns;
		logic        led_pwr;
	} state_t;

	state_t           s_r;
	state_t           s_nxt;
	pins_t            pin_raw;
	pins_t            p;
	logic [`EV_W-1:0] ev_set;
	logic [`EV_W-1:0] ev_clr;
	logic [`EV_W-1:0] ev_status;

	// Gather every outside level except pattern_tx_bit, in the field order of the pin record, for one synchroniser.
	assign pin_raw = {dte_tx_bit, line_rx_bit, carrier_present, service_violation, idle_code_detected,
		framing_error, bipolar_violation, invalid_bipolar, pattern_error, toggle_down, toggle_up, test_511,
		test_511e, local_loop_request_line, remote_loop_request_line, peer_loop_request, co_loop_active,
		no_valid_signal, line_rate_switch, front_panel_enable_switch, terminal_loop_line_enable_switch,
		remote_loop_accept_switch};

	// All pins except the bus and pattern_tx_bit pass two flip-flops before any logic reads them.
	level_sync #(
		.W ($bits(pins_t))
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (pin_raw),
		.q       (p)
	);

	// Sticky events, write-one-to-clear, masked onto the interrupt line.
	event_flags #(
		.N (`EV_W)
	) u_flags (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set     (ev_set),
		.clr     (ev_clr),
		.mask    (s_r.mask),
		.status  (ev_status),
		.irq     (irq)
	);

	// Next state: option latch, loop control, indicators, data path and bus.
	always_comb begin
		logic       act_en;
		logic       local_req;
		logic       remote_req;
		logic       peer_req;
		logic       test_on;
		logic       do_wr;
		logic [3:0] rd_ofs;
		logic [3:0] wr_ofs;
		act_en     = 1'b0;
		local_req  = 1'b0;
		remote_req = 1'b0;
		peer_req   = 1'b0;
		test_on    = 1'b0;
		do_wr      = 1'b0;
		rd_ofs     = 4'h0;
		wr_ofs     = 4'h0;
		s_nxt      = s_r;
		ev_clr     = '0;

		// The rate switch is read once, when the synchronised level is valid.
		// A later change of the switch has no effect until the next reset.
		if (!s_r.rate_known) begin
			if (s_r.rate_wait == `RATE_SETTLE) begin
				s_nxt.rate_known = 1'b1;
				s_nxt.rate_64    = p.line_rate_switch;
			end else begin
				s_nxt.rate_wait = s_r.rate_wait + 2'h1;
			end
		end

		// Toggles and the local and remote request lines act only with both enables in the Off position.
		act_en = ~p.front_panel_enable_switch & ~p.terminal_loop_line_enable_switch;
		local_req = act_en & (p.toggle_down | p.local_loop_request_line
			| s_r.ctrl[`CTRL_SW_LOCAL]);
		remote_req = act_en & (p.toggle_up | p.remote_loop_request_line
			| s_r.ctrl[`CTRL_SW_REMOTE]);
		peer_req = p.peer_loop_request & ~p.remote_loop_accept_switch;
		test_on = act_en & (p.test_511 | p.test_511e);

		// Local loop outranks a remote request raised at the same time.
		if (local_req) begin
			s_nxt.mode = MODE_LOCAL;
		end else if (remote_req) begin
			s_nxt.mode = MODE_REMOTE;
		end else if (peer_req) begin
			s_nxt.mode = MODE_RESPOND;
		end else begin
			s_nxt.mode = MODE_NORMAL;
		end
		s_nxt.pattern_on = test_on;
		s_nxt.remote_cmd = (s_nxt.mode == MODE_REMOTE);

		// Line transmit: loop the far unit's data back, or send pattern or terminal data.
		if (s_nxt.mode == MODE_RESPOND) begin
			s_nxt.line_tx = p.line_rx_bit;
		end else if (test_on) begin
			s_nxt.line_tx = pattern_tx_bit;
		end else begin
			s_nxt.line_tx = p.dte_tx_bit;
		end

		// In local loop the transmitter feeds our own receiver.
		if (s_nxt.mode == MODE_LOCAL) begin
			s_nxt.dte_rx = p.dte_tx_bit;
		end else begin
			s_nxt.dte_rx = p.line_rx_bit;
		end
		// The synchronisers leave reset at zero, a false zero bit, so both paths idle until the rate is latched.
		if (!s_r.rate_known) begin
			s_nxt.line_tx = 1'b1;
			s_nxt.dte_rx  = 1'b1;
		end

		// Data indicators light on zero bits; an idle line is marks, so they stay dark.
		s_nxt.led_tx = ~s_nxt.line_tx;
		s_nxt.led_rx = ~s_nxt.dte_rx;

		// Until the rate is latched the unit behaves as the low rate.
		if (s_r.rate_64) begin
			s_nxt.cd = p.carrier_present;
		end else begin
			s_nxt.cd = p.carrier_present & ~p.service_violation & ~p.idle_code_detected;
		end

		if (test_on) begin
			s_nxt.led_ber = p.pattern_error;
		end else if (s_r.rate_64) begin
			s_nxt.led_ber = p.framing_error | p.bipolar_violation;
		end else begin
			s_nxt.led_ber = p.invalid_bipolar;
		end

		s_nxt.led_loop = (s_nxt.mode != MODE_NORMAL) | test_on | p.co_loop_active;
		s_nxt.led_ns   = p.no_valid_signal;
		s_nxt.led_pwr  = 1'b1;

		// Events for the interrupt flags, each a one-cycle pulse.
		ev_set                   = '0;
		ev_set[`EV_CARRIER_LOST] = s_r.cd & ~s_nxt.cd;
		ev_set[`EV_BIT_ERROR]    = ~s_r.led_ber & s_nxt.led_ber;
		ev_set[`EV_LOOP_ENTER]   = ~s_r.led_loop & s_nxt.led_loop;
		ev_set[`EV_NO_SIGNAL]    = ~s_r.led_ns & s_nxt.led_ns;

		// Write address and data are taken in either order and held until both are here.
		if (awvalid && s_r.awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = wdata;
			s_nxt.w_strb = wstrb;
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end

		// Registers are byte-enabled on lane zero; all fields sit in the low byte.
		do_wr  = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
		wr_ofs = {s_r.aw_addr[3:2], 2'b00};
		if (do_wr) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = `RESP_OKAY;
		end
		// A write to the read-only status is answered but changes nothing.
		if (do_wr && s_r.w_strb[0]) begin
			unique case (wr_ofs)
				`OFS_CONTROL:    s_nxt.ctrl  = s_r.w_data[`CTRL_W-1:0];
				`OFS_STATUS:     s_nxt.bresp = `RESP_OKAY;
				`OFS_INT_STATUS: ev_clr      = s_r.w_data[`EV_W-1:0];
				`OFS_INT_MASK:   s_nxt.mask  = s_r.w_data[`EV_W-1:0];
			endcase
		end
		// Only one write stands at a time, so ready waits for the response to be taken.
		s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
		s_nxt.wready  = ~s_nxt.w_have & ~s_nxt.bvalid;

		// Reads answer one cycle after the address is taken.
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		rd_ofs = {araddr[3:2], 2'b00};
		if (arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = `RESP_OKAY;
			s_nxt.rdata  = 32'h0000_0000;
			unique case (rd_ofs)
				`OFS_CONTROL:    s_nxt.rdata[`CTRL_W-1:0] = s_r.ctrl;
				`OFS_STATUS: begin
					s_nxt.rdata[`ST_MODE_LO+:2] = s_r.mode;
					s_nxt.rdata[`ST_PATTERN]    = s_r.pattern_on;
					s_nxt.rdata[`ST_RATE_64]    = s_r.rate_64;
					s_nxt.rdata[`ST_CARRIER]    = s_r.cd;
					s_nxt.rdata[`ST_BIT_ERROR]  = s_r.led_ber;
					s_nxt.rdata[`ST_NO_SIGNAL]  = s_r.led_ns;
					s_nxt.rdata[`ST_LOOP]       = s_r.led_loop;
				end
				`OFS_INT_STATUS: s_nxt.rdata[`EV_W-1:0] = ev_status;
				`OFS_INT_MASK:   s_nxt.rdata[`EV_W-1:0] = s_r.mask;
			endcase
		end
		s_nxt.arready = ~s_nxt.rvalid;
	end

	// One register for all state; the unit starts in normal mode after reset, with both data paths idle until the rate is latched.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r         <= '0;
			s_r.mode    <= MODE_NORMAL;
			s_r.ctrl    <= `CTRL_RESET;
			s_r.mask    <= `MASK_RESET;
			s_r.line_tx <= 1'b1;
			s_r.dte_rx  <= 1'b1;
			s_r.led_pwr <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Every output comes straight from a flip-flop.
	assign awready             = s_r.awready;
	assign wready              = s_r.wready;
	assign bvalid              = s_r.bvalid;
	assign bresp               = s_r.bresp;
	assign arready             = s_r.arready;
	assign rvalid              = s_r.rvalid;
	assign rresp               = s_r.rresp;
	assign rdata               = s_r.rdata;
	assign line_tx_bit         = s_r.line_tx;
	assign dte_rx_bit          = s_r.dte_rx;
	assign carrier_detect      = s_r.cd;
	assign led_carrier         = s_r.cd;
	assign led_tx_data         = s_r.led_tx;
	assign led_rx_data         = s_r.led_rx;
	assign bit_error_indicator = s_r.led_ber;
	assign led_loop            = s_r.led_loop;
	assign no_signal_indicator = s_r.led_ns;
	assign led_power           = s_r.led_pwr;
	assign test_mode           = s_r.led_loop;
	assign pattern_test_active = s_r.pattern_on;
	assign remote_loop_command = s_r.remote_cmd;
endmodule
`default_nettype wire

// ### tb/dsu_status_loop_properties.sv
// Port-level assertions of the status and loopback block, bound to its top module.
`default_nettype none
module dsu_status_loop_properties (
	input wire logic aclk, aresetn, dte_tx_bit, line_rx_bit, carrier_present, service_violation,
	input wire logic idle_code_detected, framing_error, bipolar_violation, invalid_bipolar, pattern_error,
	input wire logic no_valid_signal, toggle_down, local_loop_request_line, peer_loop_request, co_loop_active,
	input wire logic line_rate_switch, front_panel_enable_switch, terminal_loop_line_enable_switch,
	input wire logic remote_loop_accept_switch, carrier_detect, led_tx_data, led_rx_data, bit_error_indicator,
	input wire logic led_loop, no_signal_indicator, led_power, test_mode, pattern_test_active,
	input wire logic remote_loop_command, irq
);
	logic [2:0] live_r;
	logic       rate_r;
	logic       steady;

	// Edges since release; the three-stage history is trusted only once it is full.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			live_r <= 3'h0;
		else if (live_r != 3'h7)
			live_r <= live_r + 3'h1;
	end

	// The rate is taken once per reset, so later switch moves must not change the checks.
	always_ff @(posedge aclk) begin
		if (aresetn && live_r == 3'h0)
			rate_r <= line_rate_switch;
	end

	assign steady = (live_r == 3'h7);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	power_lit_a: assert property (led_power)
		else $error("power indicator dark");
	tx_zero_a: assert property (steady && !test_mode && !$past(test_mode) |-> led_tx_data == !$past(dte_tx_bit, 3))
		else $error("transmit indicator wrong");
	rx_zero_a: assert property (steady && !test_mode && !$past(test_mode) |-> led_rx_data == !$past(line_rx_bit, 3))
		else $error("receive indicator wrong");
	cd_fast_a: assert property (steady && rate_r |-> carrier_detect == $past(carrier_present, 3))
		else $error("carrier detect wrong at high rate");
	cd_slow_a: assert property (steady && !rate_r |-> carrier_detect ==
		$past(carrier_present && !service_violation && !idle_code_detected, 3))
		else $error("carrier detect wrong at low rate");
	ber_line_a: assert property (steady && !pattern_test_active && !$past(pattern_test_active) |->
		bit_error_indicator == (rate_r ? $past(framing_error || bipolar_violation, 3) : $past(invalid_bipolar, 3)))
		else $error("line error indicator wrong");
	ber_pattern_a: assert property (steady && pattern_test_active && $past(pattern_test_active) |->
		bit_error_indicator == $past(pattern_error, 3))
		else $error("pattern error indicator wrong");
	ns_lit_a: assert property (steady |-> no_signal_indicator == $past(no_valid_signal, 3))
		else $error("no signal indicator wrong");
	co_loop_a: assert property (steady && $past(co_loop_active, 3) |-> led_loop && test_mode)
		else $error("office loop not shown");
	gate_off_a: assert property (steady && $past((front_panel_enable_switch || terminal_loop_line_enable_switch)
		&& !co_loop_active && !(peer_loop_request && !remote_loop_accept_switch), 3) |-> !led_loop)
		else $error("loop entered while requests disabled");
	local_first_a: assert property (steady && $past(!front_panel_enable_switch && !terminal_loop_line_enable_switch
		&& (toggle_down || local_loop_request_line), 3) |-> led_loop && !remote_loop_command)
		else $error("local loop not taken first");

	// Main scenarios reached.
	cover property (pattern_test_active && bit_error_indicator);
	cover property (remote_loop_command);
	cover property (irq);
endmodule

bind dsu_status_loop dsu_status_loop_properties dsu_status_loop_properties_inst (.aclk, .aresetn, .dte_tx_bit,
	.line_rx_bit, .carrier_present, .service_violation, .idle_code_detected, .framing_error, .bipolar_violation,
	.invalid_bipolar, .pattern_error, .no_valid_signal, .toggle_down, .local_loop_request_line, .peer_loop_request,
	.co_loop_active, .line_rate_switch, .front_panel_enable_switch, .terminal_loop_line_enable_switch,
	.remote_loop_accept_switch, .carrier_detect, .led_tx_data, .led_rx_data, .bit_error_indicator, .led_loop,
	.no_signal_indicator, .led_power, .test_mode, .pattern_test_active, .remote_loop_command, .irq);
`default_nettype wire

// ### tb/far_line_unit.sv
// Behavioural far-end line unit that loops our line data back on command.
`default_nettype none
module far_line_unit (
	input  wire logic aclk,
	input  wire logic line_tx_bit,
	input  wire logic remote_loop_command,
	input  wire logic own_bit,
	output var  logic line_rx_bit
);
	timeunit 1ns;
	timeprecision 1ns;

	// One cycle of line delay either way, so looped data never arrives for free.
	always_ff @(posedge aclk) begin
		line_rx_bit <= remote_loop_command ? line_tx_bit : own_bit;
	end
endmodule
`default_nettype wire

// ### tb/dsu_status_loop_tb.sv
// Self-checking testbench of the status and loopback block with a far-end line unit.
`include "dsu_map.svh"
`default_nettype none
module dsu_status_loop_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp;
	logic dte_tx_bit, line_rx_bit, pattern_tx_bit, line_tx_bit, dte_rx_bit, far_bit, carrier_present;
	logic service_violation, idle_code_detected, framing_error, bipolar_violation, invalid_bipolar;
	logic pattern_error, no_valid_signal, toggle_down, toggle_up, test_511, test_511e, co_loop_active;
	logic local_loop_request_line, remote_loop_request_line, peer_loop_request, line_rate_switch;
	logic front_panel_enable_switch, terminal_loop_line_enable_switch, remote_loop_accept_switch;
	logic carrier_detect, led_tx_data, led_rx_data, led_carrier, bit_error_indicator, led_loop, led_power;
	logic no_signal_indicator, test_mode, pattern_test_active, remote_loop_command, irq;
	int mismatches, samples_checked;

	// Free-running 25 MHz clock.
	always #20 aclk = ~aclk;

	dsu_status_loop dsu_status_loop_inst (.*);
	far_line_unit far_line_unit_inst (.aclk, .line_tx_bit, .remote_loop_command, .own_bit(far_bit), .line_rx_bit);

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	// Pin changes take three edges; the wait ends on a falling edge so outputs are settled.
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Address and data are offered together and each is released when taken.
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check({bvalid, bresp}, {1'b1, `RESP_OKAY});
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rready <= 1'b0;
		check({rvalid, rresp}, {1'b1, `RESP_OKAY});
	endtask

	task automatic do_reset(input logic rate);
		@(posedge aclk);
		aresetn <= 1'b0;
		line_rate_switch <= rate;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		settle(8);
	endtask

	// Reset values, a write to the read-only status, and a low-rate status word.
	task automatic s_regs();
		check(led_power, 1'b1);
		axi_write(`OFS_STATUS, 32'hFF);
		axi_read(`OFS_STATUS, rd);
		check(rd, 32'h10);
		axi_read(`OFS_CONTROL, rd);
		check(rd, 32'h0);
		axi_read(`OFS_INT_MASK, rd);
		check(rd, 32'h0);
	endtask

	// Zero bits light the data indicators; each low-rate cause drops carrier.
	task automatic s_lines();
		logic [2:0] causes [3] = '{3'b000, 3'b110, 3'b101};
		@(posedge aclk);
		{dte_tx_bit, far_bit, invalid_bipolar} <= 3'b001;
		settle(5);
		check({led_tx_data, led_rx_data, line_tx_bit, bit_error_indicator}, 4'hD);
		@(posedge aclk);
		{dte_tx_bit, far_bit, invalid_bipolar} <= 3'b110;
		settle(5);
		check({led_tx_data, led_rx_data}, 2'b00);
		foreach (causes[i]) begin
			@(posedge aclk);
			{carrier_present, service_violation, idle_code_detected} <= causes[i];
			settle(5);
			check({carrier_detect, led_carrier}, 2'b00);
			@(posedge aclk);
			{carrier_present, service_violation, idle_code_detected} <= 3'b100;
			settle(5);
			check({carrier_detect, led_carrier}, 2'b11);
		end
	endtask

	// High rate: carrier ignores violations; line and pattern errors; rate kept until reset.
	task automatic s_fast();
		do_reset(1'b1);
		@(posedge aclk);
		{service_violation, idle_code_detected, line_rate_switch, framing_error} <= 4'hD;
		settle(5);
		check({carrier_detect, bit_error_indicator}, 2'b11);
		axi_read(`OFS_STATUS, rd);
		check(rd[3], 1'b1);
		@(posedge aclk);
		{service_violation, idle_code_detected, framing_error, invalid_bipolar} <= 4'h1;
		settle(5);
		check(bit_error_indicator, 1'b0);
		@(posedge aclk);
		{invalid_bipolar, test_511, pattern_error} <= 3'b011;
		settle(5);
		check({pattern_test_active, led_loop, bit_error_indicator, line_tx_bit}, 4'hE);
		@(posedge aclk);
		{test_511, test_511e, pattern_error, framing_error} <= 4'b0101;
		settle(5);
		check({pattern_test_active, led_loop, bit_error_indicator}, 3'b110);
		@(posedge aclk);
		{test_511e, framing_error, bipolar_violation} <= 3'b001;
		settle(5);
		check(bit_error_indicator, 1'b1);
		@(posedge aclk);
		bipolar_violation <= 1'b0;
	endtask

	// Disabled sources are ignored; local beats remote and echoes; remote loops through the far unit.
	task automatic s_loops();
		@(posedge aclk);
		{front_panel_enable_switch, toggle_down} <= 2'b11;
		settle(5);
		check(led_loop, 1'b0);
		@(posedge aclk);
		{front_panel_enable_switch, toggle_down, terminal_loop_line_enable_switch, local_loop_request_line} <= 4'h3;
		settle(5);
		check(led_loop, 1'b0);
		@(posedge aclk);
		{terminal_loop_line_enable_switch, remote_loop_request_line, dte_tx_bit} <= 3'b010;
		settle(5);
		check({led_loop, test_mode, remote_loop_command, dte_rx_bit}, 4'hC);
		@(posedge aclk);
		dte_tx_bit <= 1'b1;
		settle(5);
		check(dte_rx_bit, 1'b1);
		@(posedge aclk);
		{local_loop_request_line, remote_loop_request_line, toggle_up, dte_tx_bit} <= 4'h2;
		settle(10);
		check({remote_loop_command, led_loop, dte_rx_bit}, 3'b110);
		@(posedge aclk);
		{toggle_up, remote_loop_request_line, dte_tx_bit} <= 3'b011;
		settle(10);
		check({remote_loop_command, dte_rx_bit}, 2'b11);
		@(posedge aclk);
		{remote_loop_request_line, toggle_down} <= 2'b01;
		settle(5);
		axi_read(`OFS_STATUS, rd);
		check({rd[7], rd[1:0]}, 3'b101);
	endtask

	// Far-unit requests obey the accept switch; the office loop is shown and then cleared.
	task automatic s_peer();
		@(posedge aclk);
		{toggle_down, peer_loop_request, far_bit} <= 3'b010;
		settle(5);
		check({led_loop, line_tx_bit}, 2'b01);
		@(posedge aclk);
		remote_loop_accept_switch <= 1'b0;
		settle(6);
		check({led_loop, line_tx_bit}, 2'b10);
		@(posedge aclk);
		{peer_loop_request, far_bit, co_loop_active, remote_loop_accept_switch} <= 4'h7;
		settle(5);
		check({led_loop, test_mode}, 2'b11);
		@(posedge aclk);
		co_loop_active <= 1'b0;
		settle(5);
		check(led_loop, 1'b0);
	endtask

	// Sticky flags, masking, clearing by writing one, and the software loop request.
	task automatic s_irq();
		axi_write(`OFS_INT_STATUS, 32'hF);
		@(posedge aclk);
		no_valid_signal <= 1'b1;
		settle(5);
		check({no_signal_indicator, irq}, 2'b10);
		axi_read(`OFS_INT_STATUS, rd);
		check(rd, 32'h8);
		axi_write(`OFS_INT_MASK, 32'h8);
		settle(2);
		check(irq, 1'b1);
		axi_write(`OFS_INT_STATUS, 32'h8);
		settle(2);
		check(irq, 1'b0);
		axi_read(`OFS_STATUS, rd);
		check(rd, 32'h58);
		axi_write(`OFS_CONTROL, 32'h1);
		settle(2);
		check(led_loop, 1'b1);
		axi_read(`OFS_INT_STATUS, rd);
		check(rd, 32'h4);
		axi_write(`OFS_CONTROL, 32'h0);
	endtask

	// Cuts a hang short; the whole run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		summarize();
	end

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{pattern_tx_bit, service_violation, idle_code_detected, framing_error, bipolar_violation} = '0;
		{invalid_bipolar, pattern_error, no_valid_signal, toggle_down, toggle_up, test_511, test_511e} = '0;
		{co_loop_active, local_loop_request_line, remote_loop_request_line, peer_loop_request} = '0;
		{line_rate_switch, front_panel_enable_switch, terminal_loop_line_enable_switch} = '0;
		{dte_tx_bit, far_bit, carrier_present, remote_loop_accept_switch} = 4'hF;
		do_reset(1'b0);
		s_regs();
		s_lines();
		s_fast();
		s_loops();
		s_peer();
		s_irq();
		summarize();
	end
endmodule
`default_nettype wire
